//--- design/qfd_cmd_decoder.sv
`timescale 1ns/10ps
// How it works
// - code, address and data move four bits per serial clock
// - reads without a byte limit stream out until the host raises chip select
// - write-class codes run only if chip select rises on a byte edge
// - while a modify cycle runs, instructions other than suspend and status or flag polls are ignored
// - suspend pauses page program and small or block wipe only
// - resume restarts a suspended cycle; it has no operands
// - status and flag polls are answered during a modify cycle
// - identity read: no address, no dummy, up to three bytes
// - three fast read codes: three address bytes, ten dummy clocks
// - otp area read: address, ten dummies, at most 65 bytes
// - latch set and clear carry no operands
// - page write codes: address plus 1 to 256 data bytes
// - otp area write: address plus 1 to 65 data bytes
// - small and block wipe take an address, whole wipe none
// - status and flag reads repeat while chip select stays low
// - status write takes one byte; flag clear takes none
// - lock read streams after address; lock write takes one byte
// - nonvolatile config read and write move exactly two bytes
// - volatile config read streams; its write takes one byte
// - enhanced config read streams; its write takes one byte
// - read data leaves on the falling serial clock edge
// - program, erase and register writes need the write latch
// - identity read during a modify cycle is decoded but not answered
module qfd_cmd_decoder (
   // core clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // serial link from the host
   input wire logic link_sclk,
   input wire logic cs_n,
   input wire logic [3:0] io_line_in,
   output logic [3:0] io_line_out,
   output logic [3:0] io_line_oe_n,
   // modify-cycle side
   input wire logic cycle_done,
   output logic exec_valid,
   output qfd_pkg::qfd_frame_t exec_frame,
   output qfd_pkg::qfd_stat_t core_stat
);
   import qfd_pkg::*;

   // ---------------------------------------------------------
   // reset release
   // ---------------------------------------------------------
   logic rst_s1_r;
   logic rst_n_r;

   // reset asserts at once, leaves on ref_clk after two flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // ---------------------------------------------------------
   // link domain: input shifting on link_sclk
   // ---------------------------------------------------------
   qfd_link_t lnk_r;
   qfd_link_t lnk_nxt;
   qfd_info_t linfo;
   qfd_stat_t st_s1_r;
   qfd_stat_t st_s2_r;
   logic in_frame_r;
   logic [10:0] hdr_nibs;
   logic [10:0] out_start;
   logic [10:0] out_k;
   logic [9:0] out_idx;
   logic lrun;
   logic poll;
   logic drv_nxt;
   logic drv_r;
   logic [7:0] out_byte;
   logic [3:0] dout_nxt;
   logic [3:0] dout_r;

   assign linfo = qfd_decode(lnk_r.fr.code);
   assign hdr_nibs = CODE_NIBS + (linfo.addr3 ? ADDR_NIBS : 11'h000);

   // frame flag: cleared at once by chip select, so the first
   // rising edge of the next frame is seen as a fresh start;
   // reset clears it too, as chip select may idle high from the start
   always_ff @(posedge link_sclk or posedge cs_n or negedge rst_n_r) begin
      if (cs_n || !rst_n_r) begin
         in_frame_r <= 1'b0;
      end else begin
         in_frame_r <= 1'b1;
      end
   end

   // next frame state; the frame record is not cleared by chip
   // select so the core can read it once the clock has stopped
   always_comb begin
      lnk_nxt = lnk_r;
      if (!in_frame_r) begin
         lnk_nxt.fr = '0;
         lnk_nxt.fr.code = {4'h0, io_line_in};
         lnk_nxt.fr.nibs = 11'h001;
         lnk_nxt.tog = ~lnk_r.tog;
      end else begin
         if (lnk_r.fr.nibs != NIB_MAX) begin
            lnk_nxt.fr.nibs = lnk_r.fr.nibs + 11'h001;
         end
         if (lnk_r.fr.nibs < CODE_NIBS) begin
            lnk_nxt.fr.code = {lnk_r.fr.code[3:0], io_line_in};
         end else if (lnk_r.fr.nibs < hdr_nibs) begin
            lnk_nxt.fr.addr = {lnk_r.fr.addr[19:0], io_line_in};
         end else if (!linfo.is_read) begin
            lnk_nxt.fr.wdata = {lnk_r.fr.wdata[11:0], io_line_in};
         end
      end
   end

   // sample all four lines on the rising edge
   always_ff @(posedge link_sclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         lnk_r <= '0;
      end else begin
         lnk_r <= lnk_nxt;
      end
   end

   // core flags are independent levels; two flops each
   always_ff @(posedge link_sclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_s1_r <= '0;
         st_s2_r <= '0;
      end else begin
         st_s1_r <= core_stat;
         st_s2_r <= st_s1_r;
      end
   end

   // ---------------------------------------------------------
   // link domain: read data out
   // ---------------------------------------------------------
   // output starts after code, address and dummy clocks
   assign out_start = hdr_nibs + {7'h00, linfo.dummy};
   assign out_k = lnk_r.fr.nibs - out_start;
   assign out_idx = out_k[10:1];
   assign lrun = st_s2_r.busy & ~st_s2_r.susp;
   assign poll = (lnk_r.fr.code == CMD_STAT_RD) ||
                 (lnk_r.fr.code == CMD_FLAG_RD);

   // during a running cycle only polls answer, so an identity or
   // array read stays silent and cannot upset the cycle
   always_comb begin
      drv_nxt = in_frame_r && linfo.known && linfo.is_read &&
                (lnk_r.fr.nibs >= out_start) &&
                (!lrun || poll);
      if (linfo.max_d != LEN_NONE && out_idx >= {1'b0, linfo.max_d}) begin
         drv_nxt = 1'b0;
      end
   end

   // byte chosen by code; array and register contents live outside
   always_comb begin
      out_byte = FILL_BYTE;
      case (lnk_r.fr.code)
         CMD_STAT_RD: begin
            out_byte = 8'h00;
            out_byte[ST_BUSY] = st_s2_r.busy;
            out_byte[ST_WEL] = st_s2_r.wel;
         end
         CMD_FLAG_RD: begin
            out_byte = 8'h00;
            out_byte[FL_READY] = ~st_s2_r.busy;
            out_byte[FL_SUSP] = st_s2_r.susp;
         end
         CMD_ID: begin
            case (out_idx)
               10'h000: out_byte = ID_VALUE[23:16];
               10'h001: out_byte = ID_VALUE[15:8];
               default: out_byte = ID_VALUE[7:0];
            endcase
         end
         default: out_byte = FILL_BYTE;
      endcase
      dout_nxt = out_k[0] ? out_byte[3:0] : out_byte[7:4];
   end

   // launch on the falling edge; chip select high stops driving
   // at once, whatever nibble was in flight; reset also parks
   // the lines, so nothing is driven before the first frame
   always_ff @(negedge link_sclk or posedge cs_n or negedge rst_n_r) begin
      if (cs_n || !rst_n_r) begin
         drv_r <= 1'b0;
         dout_r <= 4'h0;
      end else begin
         drv_r <= drv_nxt;
         dout_r <= dout_nxt;
      end
   end

   assign io_line_out = dout_r;
   assign io_line_oe_n = {4{~drv_r}};

   // ---------------------------------------------------------
   // core domain: frame end and execution
   // ---------------------------------------------------------
   qfd_core_t c_r;
   qfd_core_t c_nxt;
   qfd_info_t cinfo;
   logic end_ev;
   logic [9:0] nbytes;
   logic [9:0] hbytes;
   logic [9:0] dbytes;
   logic len_ok;
   logic running;
   logic ok;

   assign cinfo = qfd_decode(lnk_r.fr.code);
   assign nbytes = lnk_r.fr.nibs[10:1];
   assign hbytes = CODE_BYTES + (cinfo.addr3 ? ADDR_BYTES : 10'h000);
   assign dbytes = nbytes - hbytes;
   assign len_ok = (nbytes >= hbytes) &&
                   (dbytes >= {1'b0, cinfo.min_d}) &&
                   (dbytes <= {1'b0, cinfo.max_d});
   assign running = c_r.busy & ~c_r.susp;
   // a frame counts once: the toggle guards against a chip select
   // pulse with no clock, which would replay the old record
   assign end_ev = c_r.cs_s2 & ~c_r.cs_d & (c_r.tg_s2 != c_r.tg_seen);

   // decide at chip select rise; the link record is stable then
   always_comb begin
      c_nxt = c_r;
      ok = 1'b0;
      c_nxt.exec_v = 1'b0;
      c_nxt.cs_s1 = cs_n;
      c_nxt.cs_s2 = c_r.cs_s1;
      c_nxt.cs_d = c_r.cs_s2;
      c_nxt.tg_s1 = lnk_r.tog;
      c_nxt.tg_s2 = c_r.tg_s1;
      if (cycle_done) begin
         c_nxt.busy = 1'b0;
         c_nxt.susp = 1'b0;
         c_nxt.susp_ok = 1'b0;
      end
      if (end_ev) begin
         c_nxt.tg_seen = c_r.tg_s2;
         if (cinfo.known && !cinfo.is_read && !lnk_r.fr.nibs[0] &&
             len_ok) begin
            if (lnk_r.fr.code == CMD_SUSPEND) begin
               ok = running && c_r.susp_ok;
               c_nxt.susp = c_nxt.susp | ok;
            end else if (lnk_r.fr.code == CMD_RESUME) begin
               ok = c_r.busy && c_r.susp;
               c_nxt.susp = c_nxt.susp & ~ok;
            end else begin
               ok = !running &&
                    !(cinfo.need_wel && !c_r.wel) &&
                    !(c_r.susp && cinfo.starts);
               if (ok && lnk_r.fr.code == CMD_LATCH_SET) begin
                  c_nxt.wel = 1'b1;
               end
               if (ok && (cinfo.need_wel ||
                          lnk_r.fr.code == CMD_LATCH_CLR)) begin
                  c_nxt.wel = 1'b0;
               end
               if (ok && cinfo.starts) begin
                  c_nxt.busy = 1'b1;
                  c_nxt.susp_ok = cinfo.susp_ok;
               end
            end
            if (ok) begin
               c_nxt.exec_v = 1'b1;
               c_nxt.exec = lnk_r.fr;
            end
         end
      end
   end

   // core state register
   always_ff @(posedge ref_clk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         // chip select idles high, so its synchroniser starts high
         // as well and reset release shows no false rising edge
         c_r <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1, default: '0};
      end else begin
         c_r <= c_nxt;
      end
   end

   assign exec_valid = c_r.exec_v;
   assign exec_frame = c_r.exec;
   assign core_stat = '{busy: c_r.busy, susp: c_r.susp, wel: c_r.wel};

   // ---------------------------------------------------------
   // checks
   // ---------------------------------------------------------
   // shape of the instruction just run, for the checks below
   qfd_info_t xinfo;
   assign xinfo = qfd_decode(c_r.exec.code);

   busy_hold_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.busy && !cycle_done |=> c_r.busy)
      else $error("busy dropped without cycle_done");

   busy_gate_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      $past(c_r.busy && !c_r.susp) && c_r.exec_v
      |-> c_r.exec.code == CMD_SUSPEND)
      else $error("instruction run during a busy cycle");

   cycle_start_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.exec_v && xinfo.starts
      |-> c_r.busy && !c_r.susp ##1 c_r.busy || $past(cycle_done))
      else $error("modify instruction did not start busy");

   suspend_set_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.exec_v && c_r.exec.code == CMD_SUSPEND
      |-> c_r.busy && c_r.susp && $past(c_r.susp_ok))
      else $error("suspend did not pause a pausable cycle");

   resume_clr_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.exec_v && c_r.exec.code == CMD_RESUME
      |-> $past(c_r.susp) && !c_r.susp && c_r.busy)
      else $error("resume did not restart the cycle");

   latch_need_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.exec_v && xinfo.need_wel
      |-> $past(c_r.wel) && !c_r.wel)
      else $error("write ran without the write latch");

   byte_edge_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.exec_v |-> !c_r.exec.nibs[0])
      else $error("instruction ran off a byte boundary");

   page_len_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.exec_v && (c_r.exec.code == CMD_PAGE_A ||
                     c_r.exec.code == CMD_PAGE_B ||
                     c_r.exec.code == CMD_PAGE_C)
      |-> c_r.exec.nibs >= 11'h00A && c_r.exec.nibs <= 11'h208)
      else $error("page write length out of range");

   read_only_a: assert property (
      @(posedge link_sclk) disable iff (!rst_n_r)
      drv_r |-> linfo.is_read && lnk_r.fr.nibs >= out_start)
      else $error("lines driven outside a read data phase");

   out_cut_a: assert property (
      @(posedge link_sclk) disable iff (!rst_n_r)
      drv_r && linfo.max_d != LEN_NONE
      |-> out_idx < {1'b0, linfo.max_d})
      else $error("read ran past its byte count");

   poll_only_a: assert property (
      @(posedge link_sclk) disable iff (!rst_n_r)
      drv_r && lrun |-> poll)
      else $error("non-poll read answered during a cycle");

   latch_set_a: assert property (
      @(posedge ref_clk) disable iff (!rst_n_r)
      c_r.exec_v && c_r.exec.code == CMD_LATCH_SET |-> c_r.wel)
      else $error("latch set left the write latch clear");

endmodule : qfd_cmd_decoder

//--- design/qfd_pkg.sv
package qfd_pkg;
   // ---------------------------------------------------------
   // instruction codes
   // ---------------------------------------------------------
   localparam logic [7:0] CMD_ID = 8'hAF;
   localparam logic [7:0] CMD_FREAD_A = 8'h0B;
   localparam logic [7:0] CMD_FREAD_B = 8'h6B;
   localparam logic [7:0] CMD_FREAD_C = 8'hEB;
   localparam logic [7:0] CMD_OTP_RD = 8'h4B;
   localparam logic [7:0] CMD_LATCH_SET = 8'h06;
   localparam logic [7:0] CMD_LATCH_CLR = 8'h04;
   localparam logic [7:0] CMD_PAGE_A = 8'h02;
   localparam logic [7:0] CMD_PAGE_B = 8'h32;
   localparam logic [7:0] CMD_PAGE_C = 8'h12;
   localparam logic [7:0] CMD_OTP_WR = 8'h42;
   localparam logic [7:0] CMD_WIPE_SMALL = 8'h20;
   localparam logic [7:0] CMD_WIPE_BLOCK = 8'hD8;
   localparam logic [7:0] CMD_WIPE_ALL = 8'hC7;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_STAT_RD = 8'h05;
   localparam logic [7:0] CMD_STAT_WR = 8'h01;
   localparam logic [7:0] CMD_LOCK_RD = 8'hE8;
   localparam logic [7:0] CMD_LOCK_WR = 8'hE5;
   localparam logic [7:0] CMD_FLAG_RD = 8'h70;
   localparam logic [7:0] CMD_FLAG_CLR = 8'h50;
   localparam logic [7:0] CMD_NV_RD = 8'hB5;
   localparam logic [7:0] CMD_NV_WR = 8'hB1;
   localparam logic [7:0] CMD_VCFG_RD = 8'h85;
   localparam logic [7:0] CMD_VCFG_WR = 8'h81;
   localparam logic [7:0] CMD_ECFG_RD = 8'h65;
   localparam logic [7:0] CMD_ECFG_WR = 8'h61;

   // ---------------------------------------------------------
   // counts, lengths and bit positions
   // ---------------------------------------------------------
   localparam logic [3:0] DUMMY_CLKS = 4'hA;
   localparam logic [10:0] NIB_MAX = 11'h7FF;
   localparam logic [10:0] CODE_NIBS = 11'h002;
   localparam logic [10:0] ADDR_NIBS = 11'h006;
   localparam logic [9:0] CODE_BYTES = 10'h001;
   localparam logic [9:0] ADDR_BYTES = 10'h003;
   localparam logic [8:0] LEN_NONE = 9'h000;
   localparam logic [8:0] LEN_ONE = 9'h001;
   localparam logic [8:0] LEN_TWO = 9'h002;
   localparam logic [8:0] LEN_ID = 9'h003;
   localparam logic [8:0] LEN_OTP = 9'h041;
   localparam logic [8:0] LEN_PAGE = 9'h100;
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int FL_SUSP = 6;
   localparam int FL_READY = 7;
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   // identification value is arbitrary
   localparam logic [23:0] ID_VALUE = 24'h5AC301;

   // ---------------------------------------------------------
   // types
   // ---------------------------------------------------------
   typedef struct packed {
      logic known;
      logic is_read;
      logic addr3;
      logic [3:0] dummy;
      logic [8:0] min_d;
      logic [8:0] max_d;
      logic need_wel;
      logic starts;
      logic susp_ok;
   } qfd_info_t;

   typedef struct packed {
      logic [7:0] code;
      logic [23:0] addr;
      logic [15:0] wdata;
      logic [10:0] nibs;
   } qfd_frame_t;

   typedef struct packed {
      logic busy;
      logic susp;
      logic wel;
   } qfd_stat_t;

   typedef struct packed {
      qfd_frame_t fr;
      logic tog;
   } qfd_link_t;

   typedef struct packed {
      logic cs_s1;
      logic cs_s2;
      logic cs_d;
      logic tg_s1;
      logic tg_s2;
      logic tg_seen;
      logic busy;
      logic susp;
      logic susp_ok;
      logic wel;
      logic exec_v;
      qfd_frame_t exec;
   } qfd_core_t;

   // ---------------------------------------------------------
   // instruction table: shape of each code
   // ---------------------------------------------------------
   function automatic qfd_info_t qfd_decode(input logic [7:0] code);
      qfd_info_t i;
      i = '0;
      i.known = 1'b1;
      case (code)
         CMD_ID: begin
            i.is_read = 1'b1;
            i.max_d = LEN_ID;
         end
         CMD_FREAD_A, CMD_FREAD_B, CMD_FREAD_C: begin
            i.is_read = 1'b1;
            i.addr3 = 1'b1;
            i.dummy = DUMMY_CLKS;
         end
         CMD_OTP_RD: begin
            i.is_read = 1'b1;
            i.addr3 = 1'b1;
            i.dummy = DUMMY_CLKS;
            i.max_d = LEN_OTP;
         end
         CMD_LOCK_RD: begin
            i.is_read = 1'b1;
            i.addr3 = 1'b1;
         end
         CMD_STAT_RD, CMD_FLAG_RD, CMD_VCFG_RD, CMD_ECFG_RD: begin
            i.is_read = 1'b1;
         end
         CMD_NV_RD: begin
            i.is_read = 1'b1;
            i.max_d = LEN_TWO;
         end
         CMD_LATCH_SET, CMD_LATCH_CLR, CMD_RESUME, CMD_SUSPEND,
         CMD_FLAG_CLR: begin
            i.known = 1'b1;
         end
         CMD_PAGE_A, CMD_PAGE_B, CMD_PAGE_C: begin
            i.addr3 = 1'b1;
            i.min_d = LEN_ONE;
            i.max_d = LEN_PAGE;
            i.need_wel = 1'b1;
            i.starts = 1'b1;
            i.susp_ok = 1'b1;
         end
         CMD_OTP_WR: begin
            i.addr3 = 1'b1;
            i.min_d = LEN_ONE;
            i.max_d = LEN_OTP;
            i.need_wel = 1'b1;
            i.starts = 1'b1;
         end
         CMD_WIPE_SMALL, CMD_WIPE_BLOCK: begin
            i.addr3 = 1'b1;
            i.need_wel = 1'b1;
            i.starts = 1'b1;
            i.susp_ok = 1'b1;
         end
         CMD_WIPE_ALL: begin
            i.need_wel = 1'b1;
            i.starts = 1'b1;
         end
         CMD_STAT_WR, CMD_NV_WR: begin
            i.min_d = (code == CMD_NV_WR) ? LEN_TWO : LEN_ONE;
            i.max_d = i.min_d;
            i.need_wel = 1'b1;
            i.starts = 1'b1;
         end
         CMD_LOCK_WR, CMD_VCFG_WR, CMD_ECFG_WR: begin
            i.addr3 = (code == CMD_LOCK_WR);
            i.min_d = LEN_ONE;
            i.max_d = LEN_ONE;
            i.need_wel = 1'b1;
         end
         default: i.known = 1'b0;
      endcase
      return i;
   endfunction : qfd_decode
endpackage : qfd_pkg

//--- test/qfd_host_model.sv
`timescale 1ns/10ps
// ---------------------------------------------------------
// host controller on the four-wire link
// ---------------------------------------------------------
module qfd_host_model (
   // link driven by the host
   output logic link_sclk,
   output logic cs_n,
   output logic [3:0] io_line_in,
   // device answer
   input wire logic [3:0] io_line_out,
   input wire logic [3:0] io_line_oe_n
);
   logic [63:0] rx;
   int drv;

   // idle: select high, clock parked low
   initial begin
      link_sclk = 1'b0;
      cs_n = 1'b1;
      io_line_in = 4'hA;
   end

   // one frame: code, n_in host nibbles, n_out listening cycles;
   // sclk only runs inside the frame, data changes on the fall
   task automatic xfer(input logic [7:0] c, input int n_in,
      input logic [63:0] tx, input int n_out);
      logic [71:0] sh;
      sh = {c, tx << (64 - 4 * n_in)};
      rx = '0;
      drv = 0;
      cs_n = 1'b0;
      #40;
      for (int k = 0; k < 2 + n_in + n_out; k++) begin
         if (k < 2 + n_in) begin
            io_line_in = sh[71:68]; // four bits per clock
            sh = sh << 4;
         end else begin
            io_line_in = ~io_line_in; // released lines do not hold
         end
         #40 link_sclk = 1'b1;
         // device nibbles are stable at the rising edge
         if (k >= 2 + n_in && io_line_oe_n === 4'h0) begin
            drv++;
            rx = {rx[59:0], io_line_out};
         end
         #40 link_sclk = 1'b0;
      end
      #40 cs_n = 1'b1; // whole nibble count given by caller
      io_line_in = ~io_line_in;
      #120; // gap well above four core cycles
   endtask : xfer
endmodule : qfd_host_model

//--- test/quad_io_serial_flash_cmd_decoder_tb.sv
`timescale 1ns/10ps
module quad_io_serial_flash_cmd_decoder_tb;
   import qfd_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic cycle_done = 1'b0;
   logic link_sclk, cs_n, exec_valid;
   logic [3:0] io_line_in, io_line_out, io_line_oe_n;
   qfd_frame_t exec_frame, last_fr;
   qfd_stat_t core_stat;
   int error_cnt = 0;
   int n_tests = 0;
   int n_exec = 0;
   localparam logic [7:0] FAST [3] = '{CMD_FREAD_A, CMD_FREAD_B,
      CMD_FREAD_C};
   localparam logic [7:0] REGW [3] = '{CMD_VCFG_WR, CMD_ECFG_WR,
      CMD_LOCK_WR};

   always #5 ref_clk = ~ref_clk;

   qfd_cmd_decoder dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .link_sclk(link_sclk), .cs_n(cs_n), .io_line_in(io_line_in),
      .io_line_out(io_line_out), .io_line_oe_n(io_line_oe_n),
      .cycle_done(cycle_done), .exec_valid(exec_valid),
      .exec_frame(exec_frame), .core_stat(core_stat));
   qfd_host_model host (.link_sclk(link_sclk), .cs_n(cs_n),
      .io_line_in(io_line_in), .io_line_out(io_line_out),
      .io_line_oe_n(io_line_oe_n));

   // count accepted instructions and keep the last frame
   always @(posedge ref_clk) begin
      if (exec_valid === 1'b1) begin
         n_exec++;
         last_fr = exec_frame;
      end
   end

   // ---------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk

   task automatic stop_test;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test

   // non-read frame; fire says whether it must be accepted
   task automatic cmd(input logic [7:0] c, input int n,
      input logic [63:0] tx, input logic fire);
      int e;
      e = n_exec;
      host.xfer(c, n, tx, 0);
      chk(n_exec == e + fire, "accept count");
      if (fire)
         chk(last_fr.code === c, "frame code");
   endtask : cmd

   // read frame, last 16 driven nibbles and count of driven ones
   task automatic rd(input logic [7:0] c, input int n, input int o,
      input logic [63:0] exp, input int nd);
      host.xfer(c, n, 64'h123456, o);
      chk(host.rx === exp, "read data");
      chk(host.drv == nd, "driven nibbles");
   endtask : rd

   // the array logic reports the end of a modify cycle
   task automatic done_pulse;
      @(negedge ref_clk) cycle_done = 1'b1;
      @(negedge ref_clk) cycle_done = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk(core_stat.busy === 1'b0 && core_stat.susp === 1'b0, "done");
   endtask : done_pulse

   // ---------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------
   task automatic t_latch;
      chk(core_stat === 3'h0 && io_line_oe_n === 4'hF, "reset");
      cmd(CMD_LATCH_SET, 0, 0, 1'b1);
      chk(core_stat.wel === 1'b1, "latch set");
      rd(CMD_STAT_RD, 0, 4, 64'h0202, 4);
      cmd(CMD_LATCH_CLR, 0, 0, 1'b1);
      rd(CMD_STAT_RD, 0, 6, 64'h000000, 6);
   endtask : t_latch

   task automatic t_reads;
      rd(CMD_ID, 0, 8, {40'h0, ID_VALUE}, 6);
      rd(CMD_NV_RD, 0, 6, 64'hFFFF, 4);
      foreach (FAST[i])
         rd(FAST[i], 6, 14, 64'hFFFF, 4);
      rd(CMD_OTP_RD, 6, 142, '1, 130);
      rd(CMD_LOCK_RD, 6, 4, 64'hFFFF, 4);
      rd(CMD_VCFG_RD, 0, 4, 64'hFFFF, 4);
      rd(CMD_ECFG_RD, 0, 4, 64'hFFFF, 4);
      rd(CMD_FLAG_RD, 0, 4, 64'h8080, 4);
   endtask : t_reads

   task automatic t_writes;
      foreach (REGW[i]) begin
         cmd(REGW[i], 2 + 6 * (i / 2), 64'h5A, 1'b0);
         cmd(CMD_LATCH_SET, 0, 0, 1'b1);
         cmd(REGW[i], 2 + 6 * (i / 2), 64'h5A, 1'b1);
         chk(core_stat.wel === 1'b0, "latch used");
      end
      cmd(CMD_FLAG_CLR, 0, 0, 1'b1);
      cmd(CMD_LATCH_SET, 0, 0, 1'b1);
      cmd(CMD_STAT_WR, 1, 64'h3, 1'b0);
      cmd(CMD_NV_WR, 2, 64'h3C, 1'b0);
      cmd(CMD_STAT_WR, 2, 64'h3C, 1'b1);
      chk(core_stat.busy === 1'b1, "cycle busy");
   endtask : t_writes

   task automatic t_busy;
      rd(CMD_STAT_RD, 0, 4, 64'h0101, 4);
      rd(CMD_FLAG_RD, 0, 4, 64'h0000, 4);
      rd(CMD_ID, 0, 6, 64'h0, 0);
      rd(CMD_FREAD_A, 6, 14, 64'h0, 0);
      cmd(CMD_LATCH_SET, 0, 0, 1'b0);
      cmd(CMD_SUSPEND, 0, 0, 1'b0);
      done_pulse();
   endtask : t_busy

   task automatic t_suspend;
      cmd(CMD_LATCH_SET, 0, 0, 1'b1);
      cmd(CMD_PAGE_B, 8, 64'h12345678, 1'b1);
      chk(last_fr.addr === 24'h123456, "page addr");
      chk(last_fr.wdata[7:0] === 8'h78, "page data");
      cmd(CMD_SUSPEND, 0, 0, 1'b1);
      chk(core_stat.susp === 1'b1, "paused");
      rd(CMD_FLAG_RD, 0, 4, 64'h4040, 4);
      cmd(CMD_RESUME, 0, 0, 1'b1);
      chk(core_stat.susp === 1'b0, "resumed");
      chk(core_stat.busy === 1'b1, "still busy");
      done_pulse();
   endtask : t_suspend

   task automatic t_wipes;
      cmd(CMD_WIPE_SMALL, 6, 64'hABCDEF, 1'b0);
      for (int i = 0; i < 3; i++) begin
         cmd(CMD_LATCH_SET, 0, 0, 1'b1);
         cmd(i == 0 ? CMD_WIPE_SMALL : i == 1 ? CMD_WIPE_BLOCK :
            CMD_WIPE_ALL, i == 2 ? 0 : 6, 64'hABCDEF, 1'b1);
         chk(last_fr.nibs === (i == 2 ? 11'h002 : 11'h008),
            "wipe length");
         done_pulse();
      end
      // otp area write runs but cannot be paused
      cmd(CMD_LATCH_SET, 0, 0, 1'b1);
      cmd(CMD_OTP_WR, 8, 64'h4B, 1'b1);
      cmd(CMD_SUSPEND, 0, 0, 1'b0);
      done_pulse();
   endtask : t_wipes

   // reset through the first cycles, then all scenarios
   initial begin
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      repeat (4) @(negedge ref_clk);
      t_latch();
      t_reads();
      t_writes();
      t_busy();
      t_suspend();
      t_wipes();
      stop_test();
   end

   // watchdog: the sequence needs well under this span
   initial begin
      #500000;
      error_cnt++;
      stop_test();
   end
endmodule : quad_io_serial_flash_cmd_decoder_tb
